// File: rtl/pge_pkg.sv
package pge_pkg;

   // ----------------------------------------------------------------------
   // Widths of the pin and flag fields.
   // ----------------------------------------------------------------------
   localparam int PGE_PINS     = 12;                  // Event pins and unit count per kind.
   localparam int PGE_CAP_BITS = 16;                  // Capture flags: 12 units plus 4 egress.
   localparam int PGE_EGR_BITS = 4;                   // Egress time-stamp events, two per port.

   // ----------------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ----------------------------------------------------------------------
   localparam logic [11:0] IDX_PIN_SNAPSHOT = 12'h680; // Live pin levels, read only.
   localparam logic [11:0] IDX_PIN_DIR      = 12'h682; // Per-pin direction select.
   localparam logic [11:0] IDX_TRIG_FLAGS   = 12'h688; // Trigger unit flags, write one to clear.
   localparam logic [11:0] IDX_TRIG_MASK    = 12'h68a; // Trigger unit enables.
   localparam logic [11:0] IDX_CAP_FLAGS    = 12'h68c; // Capture flags, write one to clear.
   localparam logic [11:0] IDX_CAP_MASK     = 12'h68e; // Capture enables.

   localparam logic [15:0] ADDR_PIN_SNAPSHOT = 16'(IDX_PIN_SNAPSHOT * 4); // Byte address.
   localparam logic [15:0] ADDR_PIN_DIR      = 16'(IDX_PIN_DIR * 4);      // Byte address.
   localparam logic [15:0] ADDR_TRIG_FLAGS   = 16'(IDX_TRIG_FLAGS * 4);   // Byte address.
   localparam logic [15:0] ADDR_TRIG_MASK    = 16'(IDX_TRIG_MASK * 4);    // Byte address.
   localparam logic [15:0] ADDR_CAP_FLAGS    = 16'(IDX_CAP_FLAGS * 4);    // Byte address.
   localparam logic [15:0] ADDR_CAP_MASK     = 16'(IDX_CAP_MASK * 4);     // Byte address.

   // ----------------------------------------------------------------------
   // Reset values and bit positions.
   // ----------------------------------------------------------------------
   localparam logic [11:0] RST_PIN_DIR    = 12'h000;  // All pins start as trigger outputs.
   localparam logic [11:0] RST_TRIG_FLAGS = 12'h000;  // No trigger flag pending.
   localparam logic [11:0] RST_TRIG_MASK  = 12'h000;  // All trigger enables off.
   localparam logic [15:0] RST_CAP_FLAGS  = 16'h0000; // No capture flag pending.
   localparam logic [15:0] RST_CAP_MASK   = 16'h0000; // All capture enables off.
   localparam int          CAP_EGR_LSB    = 12;       // Egress flags sit at bits 15..12.
   localparam int          TOP_TRIG_BIT   = 10;       // Merged trigger bit in top flags/mask.
   localparam int          TOP_CAP_BIT    = 12;       // Merged capture bit in top flags/mask.

   // Register selected by a bus address.
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_SNAP,
      SEL_DIR,
      SEL_TFLAG,
      SEL_TMASK,
      SEL_CFLAG,
      SEL_CMASK
   } pge_sel_t;

endpackage : pge_pkg

// File: rtl/pge_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous pin levels.
module pge_sync
#(
   parameter int WIDTH = 12                          // Number of bits synchronised.
)
(
   input  wire logic             clk_i,              // System clock.
   input  wire logic             rst_i,              // Asynchronous reset, active high.
   input  wire logic [WIDTH-1:0] async_i,            // Levels from outside the clock domain.
   output logic      [WIDTH-1:0] sync_o              // Levels after two flip-flops.
);

   // ----------------------------------------------------------------------
   // State of the two stages.
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] meta;                         // First stage, read only by the second.
      logic [WIDTH-1:0] stable;                       // Second stage, safe to use.
   } pge_sync_state_t;

   pge_sync_state_t st_reg;                           // Registered state.
   pge_sync_state_t st_next;                          // Next state.

   // The first stage may go metastable, so only the second stage reads it.
   always_comb
   begin
      st_next        = st_reg;
      st_next.meta   = async_i;
      st_next.stable = st_reg.meta;
   end

   // Both stages clear to zero under reset.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign sync_o = st_reg.stable;

endmodule : pge_sync

// File: rtl/pge_top.sv
`timescale 1ns/1ns
module pge_top
   import pge_pkg::*;
(
   input  wire logic        CLOCK_I,                  // System clock, 10 MHz.
   input  wire logic        RESET_I,                  // Asynchronous reset, active high.
   input  wire logic        PSEL_I,                   // APB select.
   input  wire logic        PENABLE_I,                // APB access phase.
   input  wire logic        PWRITE_I,                 // APB direction, high for write.
   input  wire logic [15:0] PADDR_I,                  // APB byte address.
   input  wire logic [31:0] PWDATA_I,                 // APB write data.
   input  wire logic [3:0]  PSTRB_I,                  // APB byte strobes.
   output logic             PREADY_O,                 // APB ready, from a flip-flop.
   output logic      [31:0] PRDATA_O,                 // APB read data, from a flip-flop.
   output logic             PSLVERR_O,                // APB error for unmapped address.
   input  wire logic [11:0] GPIO_I,                   // Pin levels, asynchronous.
   output logic      [11:0] GPIO_O,                   // Pin drive values.
   output logic      [11:0] GPIO_OE_O,                // Pin output enables, high drives.
   input  wire logic [11:0] TRIG_OUT_I,               // Trigger unit output levels.
   input  wire logic [11:0] TRIG_EVT_I,               // Trigger unit done or error pulses.
   output logic      [11:0] CAP_IN_O,                 // Pin levels handed to capture units.
   input  wire logic [11:0] CAP_RDY_I,                // Capture unit ready levels.
   input  wire logic [3:0]  EGRESS_TS_EVT_I,          // Egress stamp available pulses.
   output logic      [15:0] TOP_IRQ_FLAGS_O,          // Merged status, bits 10 and 12.
   output logic      [15:0] TOP_IRQ_MASK_O,           // Merged enables, bits 10 and 12.
   output logic             IRQ_O                     // Interrupt request, active high.
);

   // ----------------------------------------------------------------------
   // Module state.
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [11:0] dir;                               // Direction select per pin.
      logic [11:0] trig_flag;                         // Trigger flags.
      logic [11:0] trig_mask;                         // Trigger enables.
      logic [15:0] cap_flag;                          // Capture flags.
      logic [15:0] cap_mask;                          // Capture enables.
      logic [11:0] rdy_prev;                          // Ready levels of the last cycle.
      logic        ready;                             // Bus ready.
      logic [31:0] rdata;                             // Bus read data.
      logic        slverr;                            // Bus error.
      logic [11:0] gpio_out;                          // Pin drive values.
      logic [11:0] gpio_oe;                           // Pin output enables.
      logic [11:0] cap_in;                            // Pin levels for capture units.
      logic [15:0] top_flags;                         // Merged status image.
      logic [15:0] top_mask;                          // Merged enable image.
      logic        irq;                               // Interrupt request.
   } pge_state_t;

   pge_state_t  st_reg;                               // Registered state.
   pge_state_t  st_next;                              // Next state.
   logic [11:0] pin_sync;                             // Pin levels after synchronising.

   // ----------------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------------

   // Decodes a byte address; used by both the read and the write path.
   function automatic pge_sel_t reg_sel(input logic [15:0] addr);
      pge_sel_t sel;
      sel = SEL_NONE;
      case (addr)
         ADDR_PIN_SNAPSHOT: sel = SEL_SNAP;
         ADDR_PIN_DIR:      sel = SEL_DIR;
         ADDR_TRIG_FLAGS:   sel = SEL_TFLAG;
         ADDR_TRIG_MASK:    sel = SEL_TMASK;
         ADDR_CAP_FLAGS:    sel = SEL_CFLAG;
         ADDR_CAP_MASK:     sel = SEL_CMASK;
         default:           sel = SEL_NONE;
      endcase
      return sel;
   endfunction : reg_sel

   // Turns the two low byte strobes into a bit mask for the 16-bit fields.
   function automatic logic [15:0] lane_mask(input logic [3:0] strb);
      return {{8{strb[1]}}, {8{strb[0]}}};
   endfunction : lane_mask

   // ----------------------------------------------------------------------
   // Pin synchroniser.
   // ----------------------------------------------------------------------

   // Pins change at any time, so they pass two flip-flops before use.
   pge_sync #(
      .WIDTH   (PGE_PINS)
   ) u_pin_sync (
      .clk_i   (CLOCK_I),
      .rst_i   (RESET_I),
      .async_i (GPIO_I),
      .sync_o  (pin_sync)
   );

   // ----------------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------------

   // One process computes the bus answer, the registers, the flags and the
   // pin controls. The bus answers with one wait state so that read data
   // and ready both come from flip-flops.
   always_comb
   begin
      logic        setup_done;                        // Access phase, ready not yet given.
      logic        wr_take;                           // Write takes effect at this edge.
      logic [15:0] wmask;                             // Written bits after strobes.
      logic [15:0] wbits;                             // Data bits that are written.
      logic [11:0] rdy_rise;                          // Capture ready rising edges.
      logic [11:0] trig_clr;                          // Trigger flags cleared by software.
      logic [15:0] cap_clr;                           // Capture flags cleared by software.
      pge_sel_t    sel;                               // Addressed register.

      st_next    = st_reg;
      sel        = reg_sel(PADDR_I);
      setup_done = PSEL_I & PENABLE_I & ~st_reg.ready;
      wr_take    = PSEL_I & PENABLE_I & st_reg.ready & PWRITE_I;
      wmask      = lane_mask(PSTRB_I);
      wbits      = PWDATA_I[15:0] & wmask;
      trig_clr   = '0;
      cap_clr    = '0;
      rdy_rise   = CAP_RDY_I & ~st_reg.rdy_prev;

      // Ready is high for one cycle; the edge that samples it completes.
      // The error flag is registered together with ready, so the pin needs no gate.
      st_next.ready  = setup_done;
      st_next.slverr = setup_done & (sel == SEL_NONE);
      if (setup_done)
      begin
         // Read data are fixed in the cycle before ready is seen.
         st_next.rdata  = '0;
         if (!PWRITE_I)
         begin
            case (sel)
               SEL_SNAP:  st_next.rdata[11:0] = pin_sync;
               SEL_DIR:   st_next.rdata[11:0] = st_reg.dir;
               SEL_TFLAG: st_next.rdata[11:0] = st_reg.trig_flag;
               SEL_TMASK: st_next.rdata[11:0] = st_reg.trig_mask;
               SEL_CFLAG: st_next.rdata[15:0] = st_reg.cap_flag;
               SEL_CMASK: st_next.rdata[15:0] = st_reg.cap_mask;
               default:   st_next.rdata       = '0;
            endcase
         end
      end

      // Writes land only at the completing edge; unmapped ones are dropped.
      if (wr_take)
      begin
         case (sel)
            SEL_DIR:
            begin
               st_next.dir = (st_reg.dir & ~wmask[11:0]) | wbits[11:0];
            end
            SEL_TFLAG:
            begin
               trig_clr = wbits[11:0];
            end
            SEL_TMASK:
            begin
               st_next.trig_mask = (st_reg.trig_mask & ~wmask[11:0]) | wbits[11:0];
            end
            SEL_CFLAG:
            begin
               cap_clr = wbits;
            end
            SEL_CMASK:
            begin
               st_next.cap_mask = (st_reg.cap_mask & ~wmask) | wbits;
            end
            default:
            begin
               trig_clr = '0;
            end
         endcase
      end

      // Flags: the clear is applied first, so a coinciding event still sets.
      st_next.rdy_prev  = CAP_RDY_I;
      st_next.trig_flag = (st_reg.trig_flag & ~trig_clr) | TRIG_EVT_I;
      st_next.cap_flag  = (st_reg.cap_flag & ~cap_clr)
                          | {EGRESS_TS_EVT_I, rdy_rise};

      // Pins: direction zero drives the trigger output, one feeds capture.
      st_next.gpio_oe  = ~st_next.dir;
      st_next.gpio_out = TRIG_OUT_I & ~st_next.dir;
      st_next.cap_in   = pin_sync & st_next.dir;

      // Merged images follow the flags in the same cycle that they change.
      st_next.top_flags               = '0;
      st_next.top_mask                = '0;
      st_next.top_flags[TOP_TRIG_BIT] = |st_next.trig_flag;
      st_next.top_flags[TOP_CAP_BIT]  = |st_next.cap_flag;
      st_next.top_mask[TOP_TRIG_BIT]  = |st_next.trig_mask;
      st_next.top_mask[TOP_CAP_BIT]   = |st_next.cap_mask;
      st_next.irq = |(st_next.top_flags & st_next.top_mask);
   end

   // ----------------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------------

   // Reset gives every register its reset value; the pins come up as
   // driven trigger outputs, which suits a board that expects outputs.
   always_ff @(posedge CLOCK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         st_reg           <= '0;
         st_reg.dir       <= RST_PIN_DIR;
         st_reg.trig_flag <= RST_TRIG_FLAGS;
         st_reg.trig_mask <= RST_TRIG_MASK;
         st_reg.cap_flag  <= RST_CAP_FLAGS;
         st_reg.cap_mask  <= RST_CAP_MASK;
         st_reg.gpio_oe   <= ~RST_PIN_DIR;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, all straight from the state register.
   // ----------------------------------------------------------------------
   assign PREADY_O        = st_reg.ready;
   assign PRDATA_O        = st_reg.rdata;
   assign PSLVERR_O       = st_reg.slverr;
   assign GPIO_O          = st_reg.gpio_out;
   assign GPIO_OE_O       = st_reg.gpio_oe;
   assign CAP_IN_O        = st_reg.cap_in;
   assign TOP_IRQ_FLAGS_O = st_reg.top_flags;
   assign TOP_IRQ_MASK_O  = st_reg.top_mask;
   assign IRQ_O           = st_reg.irq;

   // ----------------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);

   // A snapshot read returns the synchronised levels of the first access cycle.
   AST_SNAPSHOT_READ: assert property (
      (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I && PADDR_I == ADDR_PIN_SNAPSHOT)
      |=> (PREADY_O && PRDATA_O == {20'h00000, $past(pin_sync)}))
      else $error("Snapshot read data differs from pin levels.");

   // A full direction write changes the output enables one cycle later.
   AST_DIR_TO_OE: assert property (
      (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == ADDR_PIN_DIR && PSTRB_I[1:0] == 2'h3)
      |=> (GPIO_OE_O == ~$past(PWDATA_I[11:0]) && CAP_IN_O == ($past(pin_sync) & $past(PWDATA_I[11:0]))))
      else $error("Output enables do not follow direction write.");

   // A trigger event is held as a flag in the next cycle, even under a clear.
   AST_TRIG_SET: assert property (
      (TRIG_EVT_I != 12'h000) |=> ((st_reg.trig_flag & $past(TRIG_EVT_I)) == $past(TRIG_EVT_I)))
      else $error("Trigger event lost.");

   // Merged trigger status tracks the OR of the flags.
   AST_TRIG_MERGE: assert property (
      TOP_IRQ_FLAGS_O[TOP_TRIG_BIT] == (st_reg.trig_flag != 12'h000))
      else $error("Top trigger status bit wrong.");

   // A write of ones without a coinciding event clears those trigger flags.
   AST_TRIG_CLEAR: assert property (
      (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == ADDR_TRIG_FLAGS
       && PSTRB_I[1:0] == 2'h3 && TRIG_EVT_I == 12'h000)
      |=> ((st_reg.trig_flag & $past(PWDATA_I[11:0])) == 12'h000))
      else $error("Trigger flag not cleared by write of one.");

   // Merged trigger enable tracks the OR of the enables.
   AST_TRIG_MASK_MERGE: assert property (
      TOP_IRQ_MASK_O[TOP_TRIG_BIT] == (st_reg.trig_mask != 12'h000))
      else $error("Top trigger enable bit wrong.");

   // Egress events land on capture flags 15 down to 12.
   AST_EGRESS_SET: assert property (
      (EGRESS_TS_EVT_I != 4'h0)
      |=> ((st_reg.cap_flag[15:12] & $past(EGRESS_TS_EVT_I)) == $past(EGRESS_TS_EVT_I)))
      else $error("Egress stamp event lost.");

   // A rising ready sets the matching flag in the next cycle.
   AST_READY_RISE: assert property (
      (CAP_RDY_I[0] && !st_reg.rdy_prev[0]) |=> (st_reg.cap_flag[0] && st_reg.rdy_prev[0]))
      else $error("Capture ready edge not flagged.");

   // Merged capture status tracks the OR of all sixteen flags.
   AST_CAP_MERGE: assert property (
      TOP_IRQ_FLAGS_O[TOP_CAP_BIT] == (st_reg.cap_flag != 16'h0000))
      else $error("Top capture status bit wrong.");

   // A write of ones without coinciding events clears those capture flags.
   AST_CAP_CLEAR: assert property (
      (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == ADDR_CAP_FLAGS
       && PSTRB_I[1:0] == 2'h3 && EGRESS_TS_EVT_I == 4'h0 && CAP_RDY_I == st_reg.rdy_prev)
      |=> ((st_reg.cap_flag & $past(PWDATA_I[15:0])) == 16'h0000))
      else $error("Capture flag not cleared by write of one.");

   // Merged capture enable tracks the OR of the enables.
   AST_CAP_MASK_MERGE: assert property (
      TOP_IRQ_MASK_O[TOP_CAP_BIT] == (st_reg.cap_mask != 16'h0000))
      else $error("Top capture enable bit wrong.");

   // The request needs a merged status bit with its merged enable.
   AST_IRQ_GATE: assert property (
      IRQ_O == ((TOP_IRQ_FLAGS_O[TOP_TRIG_BIT] && TOP_IRQ_MASK_O[TOP_TRIG_BIT])
                || (TOP_IRQ_FLAGS_O[TOP_CAP_BIT] && TOP_IRQ_MASK_O[TOP_CAP_BIT])))
      else $error("Interrupt request not gated by enables.");

endmodule : pge_top

// File: testbench/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin err_total++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb_top
   import pge_pkg::*;
;
   // ----------------------------------------------------------------------
   // Stimulus, observation and bookkeeping.
   // ----------------------------------------------------------------------
   logic        clock_i   = 1'b0;  // Bench clock, 100 ns period.
   logic        reset_i   = 1'b1;  // Reset, held at start.
   logic        psel      = 1'b0;  // APB select.
   logic        penable   = 1'b0;  // APB access phase.
   logic        pwrite    = 1'b0;  // APB direction.
   logic [15:0] paddr     = 16'h0; // APB byte address.
   logic [31:0] pwdata    = 32'h0; // APB write data.
   logic [11:0] gpio      = 12'h0; // Pin levels.
   logic [11:0] trig_out  = 12'h0; // Trigger unit output levels.
   logic [11:0] trig_evt  = 12'h0; // Trigger unit done pulses.
   logic [11:0] cap_rdy   = 12'h0; // Capture unit ready levels.
   logic [3:0]  egr_evt   = 4'h0;  // Egress stamp pulses.
   logic        pready;            // Observed ready.
   logic [31:0] prdata;            // Observed read data.
   logic        pslverr;           // Observed error.
   logic [11:0] gpio_o, gpio_oe, cap_in; // Observed pin side.
   logic [15:0] top_flags, top_mask;    // Observed merged bits.
   logic        irq;               // Observed interrupt request.
   logic [31:0] rdata;             // Data of the last transfer.
   logic        rerr;              // Error of the last transfer.
   int          err_total    = 0;  // Mismatches seen.
   int          total_checks = 0;  // Comparisons made.

   pge_top uut (.CLOCK_I(clock_i), .RESET_I(reset_i), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'h3), .PREADY_O(pready), .PRDATA_O(prdata),
      .PSLVERR_O(pslverr), .GPIO_I(gpio), .GPIO_O(gpio_o), .GPIO_OE_O(gpio_oe), .TRIG_OUT_I(trig_out),
      .TRIG_EVT_I(trig_evt), .CAP_IN_O(cap_in), .CAP_RDY_I(cap_rdy), .EGRESS_TS_EVT_I(egr_evt),
      .TOP_IRQ_FLAGS_O(top_flags), .TOP_IRQ_MASK_O(top_mask), .IRQ_O(irq));

   // Free-running clock; the half period gives 10 MHz.
   always #50 clock_i = ~clock_i;

   // ----------------------------------------------------------------------
   // Tasks.
   // ----------------------------------------------------------------------
   // Prints the verdict and stops; also reached when a wait runs out.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   // One APB transfer; the request is held until ready is sampled high.
   task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clock_i);
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= wd;
      penable <= 1'b0;
      @(posedge clock_i);
      penable <= 1'b1;
      do
      begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 16)
      begin
         err_total++;
         $display("MISMATCH t=%0t no ready", $time);
         complete_run();
      end
   endtask : apb

   // Reads a register and compares it with the expected word.
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string m);
      apb(a, 1'b0, 32'h0);
      `CHK(rdata, exp, m)
   endtask : rd_chk

   // Lets registered outputs follow; the hazard avoided is sampling on the edge.
   task automatic settle();
      repeat (2) @(posedge clock_i);
      #1;
   endtask : settle

   // One-cycle event pulse on the trigger and egress inputs.
   task automatic pulse(input logic [11:0] t, input logic [3:0] e);
      @(posedge clock_i);
      trig_evt <= t;
      egr_evt  <= e;
      @(posedge clock_i);
      trig_evt <= 12'h0;
      egr_evt  <= 4'h0;
      settle();
   endtask : pulse

   // ----------------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clock_i);
      reset_i <= 1'b0;
      #1;
      `CHK(gpio_oe, 12'hfff, "reset oe")
      `CHK(gpio_o, 12'h000, "reset drive")
      `CHK(top_flags, 16'h0000, "reset top flags")
      `CHK(top_mask, 16'h0000, "reset top mask")
      `CHK(irq, 1'b0, "reset irq")
      rd_chk(ADDR_PIN_DIR, 32'h0, "reset dir");
      rd_chk(ADDR_TRIG_FLAGS, 32'h0, "reset tflags");
      rd_chk(ADDR_TRIG_MASK, 32'h0, "reset tmask");
      rd_chk(ADDR_CAP_FLAGS, 32'h0, "reset cflags");
      rd_chk(ADDR_CAP_MASK, 32'h0, "reset cmask");
      $display("test reset done");
      @(posedge clock_i);
      gpio <= 12'ha5c; trig_out <= 12'hfff;
      repeat (3) @(posedge clock_i);
      rd_chk(ADDR_PIN_SNAPSHOT, 32'h00000a5c, "snapshot");
      apb(ADDR_PIN_SNAPSHOT, 1'b1, 32'h0000ffff);
      `CHK(rerr, 1'b0, "mapped no err")
      rd_chk(ADDR_PIN_SNAPSHOT, 32'h00000a5c, "snapshot ro");
      apb(ADDR_PIN_DIR, 1'b1, 32'h0000f0f0);
      rd_chk(ADDR_PIN_DIR, 32'h000000f0, "dir rw");
      settle();
      `CHK(gpio_oe, 12'hf0f, "oe")
      `CHK(gpio_o, 12'hf0f, "drive")
      `CHK(cap_in, 12'h050, "cap in")
      $display("test pins done");
      pulse(12'h801, 4'h0);
      `CHK(top_flags, 16'h0400, "trig merge")
      `CHK(irq, 1'b0, "irq masked")
      rd_chk(ADDR_TRIG_FLAGS, 32'h00000801, "tflags");
      apb(ADDR_TRIG_MASK, 1'b1, 32'h0000f001);
      settle();
      `CHK(top_mask, 16'h0400, "tmask merge")
      `CHK(irq, 1'b1, "irq on")
      rd_chk(ADDR_TRIG_MASK, 32'h00000001, "tmask");
      apb(ADDR_TRIG_FLAGS, 1'b1, 32'h00000800);
      rd_chk(ADDR_TRIG_FLAGS, 32'h00000001, "w1c one");
      apb(ADDR_TRIG_FLAGS, 1'b1, 32'h00000001);
      trig_evt <= 12'h002;
      apb(ADDR_TRIG_FLAGS, 1'b1, 32'h00000002);
      trig_evt <= 12'h000;
      rd_chk(ADDR_TRIG_FLAGS, 32'h00000002, "set wins");
      apb(ADDR_TRIG_FLAGS, 1'b1, 32'h00000002);
      settle();
      `CHK(top_flags, 16'h0000, "trig cleared")
      `CHK(irq, 1'b0, "irq off")
      $display("test trigger done");
      for (int i = 0; i < 4; i++)
      begin
         pulse(12'h0, 4'(4'h1 << i));
         rd_chk(ADDR_CAP_FLAGS, 32'(16'h1000 << i), "egress flag");
         apb(ADDR_CAP_FLAGS, 1'b1, 32'(16'h1000 << i));
      end
      @(posedge clock_i);
      cap_rdy <= 12'h801;
      settle();
      rd_chk(ADDR_CAP_FLAGS, 32'h00000801, "ready flag");
      `CHK(top_flags, 16'h1000, "cap merge")
      apb(ADDR_CAP_FLAGS, 1'b1, 32'h00000801);
      settle();
      rd_chk(ADDR_CAP_FLAGS, 32'h0, "held level no reset");
      cap_rdy <= 12'h0;
      apb(ADDR_CAP_MASK, 1'b1, 32'h00008000);
      rd_chk(ADDR_CAP_MASK, 32'h00008000, "cmask");
      `CHK(top_mask, 16'h1400, "cmask merge")
      pulse(12'h0, 4'h8);
      `CHK(irq, 1'b1, "cap irq")
      $display("test capture done");
      apb(16'h0100, 1'b0, 32'h0);
      `CHK(rerr, 1'b1, "unmapped err")
      `CHK(rdata, 32'h0, "unmapped data")
      $display("test unmapped done");
      complete_run();
   end
endmodule : tb_top
